/* rtl/lstbc_consts.svh */
// Offsets, field positions, reset values and timing counts of the time base
`ifndef LSTBC_CONSTS_SVH
`define LSTBC_CONSTS_SVH

// Special function register addresses
`define LSTBC_ADDR_TAPS       16'hF060
`define LSTBC_ADDR_TRIM_LO    16'hF062
`define LSTBC_ADDR_TRIM_HI    16'hF063
`define LSTBC_ADDR_SEL_LO     16'hF064
`define LSTBC_ADDR_SEL_HI     16'hF065

// Reset values
`define LSTBC_RST_TRIM_LO     8'h00
`define LSTBC_RST_TRIM_HI     8'h00
`define LSTBC_RST_SEL_LO      8'h30
`define LSTBC_RST_SEL_HI      8'h06
`define LSTBC_RST_CHAIN       15'h0000

// Writable bits of the bytes that have reserved bits
`define LSTBC_MASK_TRIM_HI    8'h07
`define LSTBC_MASK_SEL_LO     8'h77
`define LSTBC_MASK_SEL_HI     8'h07

// Select field positions
`define LSTBC_SEL0_LSB        0
`define LSTBC_SEL1_LSB        4
`define LSTBC_SEL2_LSB        8

// Chain layout: bit 0 is the 16 kHz stage, bits 14..7 are 128 Hz .. 1 Hz
`define LSTBC_CHAIN_W         15
`define LSTBC_SLOW_LSB        7
`define LSTBC_TRIM_W          11
`define LSTBC_TRIM_PHASE_W    21
`define LSTBC_TRIM_SLOT_LSB   10

// Timing: half period of the slow clock, system clock period
`define LSTBC_SLOW_HALF_NS    15259
`define LSTBC_CLK_NS          100
`define LSTBC_HALF_CYC        ((`LSTBC_SLOW_HALF_NS) / (`LSTBC_CLK_NS))

// Controller register offsets (APB byte addresses)
`define LSTBC_HOST_ADDR       8'h00
`define LSTBC_HOST_WDATA      8'h04
`define LSTBC_HOST_CMD        8'h08
`define LSTBC_HOST_STATUS     8'h0C
`define LSTBC_HOST_RDATA      8'h10
`define LSTBC_HOST_REQ        8'h14
`define LSTBC_HOST_ENABLE     8'h18
`define LSTBC_CMD_WRITE_BIT   0
`define LSTBC_CMD_WORD_BIT    1
`define LSTBC_RST_ENABLE      3'h7

`endif

/* rtl/lstbc_pkg.sv */
// Types used by the two ends of the time base: host states and tap select
package lstbc_pkg;
	typedef enum logic [2:0] {
		HOST_IDLE = 3'b001,
		HOST_REQ  = 3'b010,
		HOST_WAIT = 3'b100
	} lstbc_host_state_t;

	typedef logic [2:0] lstbc_tap_sel_t;
endpackage : lstbc_pkg

/* rtl/lstbc_if.sv */
// Register port and interrupt lines between the time base and its controller
`timescale 1ns/10ps
interface lstbc_if;
	logic        sfrSel;
	logic        sfrWrite;
	logic        sfrWord;
	logic [15:0] sfrAddr;
	logic [15:0] sfrWdata;
	logic [15:0] sfrRdata;
	logic        sfrAck;
	logic [2:0]  tickIrq;

	modport dev (
		input  sfrSel,
		input  sfrWrite,
		input  sfrWord,
		input  sfrAddr,
		input  sfrWdata,
		output sfrRdata,
		output sfrAck,
		output tickIrq
	);

	modport host (
		output sfrSel,
		output sfrWrite,
		output sfrWord,
		output sfrAddr,
		output sfrWdata,
		input  sfrRdata,
		input  sfrAck,
		input  tickIrq
	);
endinterface : lstbc_if

/* rtl/lstbc_device.sv */
// Low-speed time base: divider chain, trim, tap readback and tick interrupts
//
// Operation
// (R1) Binary chain gives 32 kHz to 1 Hz taps
// (R2) Chain starts at zero, advances on falling edge
// (R3) Readback byte shows live 128 Hz..1 Hz taps
// (R4) Any readback write zeroes 128 Hz..1 Hz stages
// (R5) Clearing high selected tap raises a request
// (R6) Three sources fire on selected tap falling
// (R7) Source 0 select bits 2..0, default 128 Hz
// (R8) Source 1 select bits 6..4, default 16 Hz
// (R9) Source 2 select bits 10..8, default 2 Hz
// (R10) Codes halve rate upward; select resets 0630H
// (R11) Select change may itself raise a request
// (R12) Eleven-bit signed trim, 0.48 ppm steps
// (R13) Software code is ratio times 2097152
// (R14) Trim touches only 8 kHz..1 Hz taps
// (R15) Trim as word or two bytes, reset zero
// (R16) Software reads taps twice until equal
// (R17) Software masks, writes readback, clears request
// (R18) Request flag set one cycle after event
// (R19) Software waits one instruction before clearing
// (R20) Each request is one-cycle system-clock pulse
// (R21) Trim adds or drops counts over 2097152
`timescale 1ns/10ps
`include "lstbc_consts.svh"
module lstbc_device #(
	parameter int HALF_CYC = `LSTBC_HALF_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	lstbc_if.dev             link,
	output logic [15:0]      tapBus
);
	logic [7:0]                        halfCnt;
	logic                              halfTick;
	logic                              slowClock;
	logic                              slowFall;
	logic [`LSTBC_CHAIN_W-1:0]         slowDividerChain;
	logic [`LSTBC_CHAIN_W-1:0]         next_chain;
	logic                              upperAdvance;
	logic [`LSTBC_TRIM_PHASE_W-1:0]    trimPhase;
	logic [7:0]                        trimLow;
	logic [7:0]                        trimHigh;
	logic [7:0]                        irqSelectLow;
	logic [7:0]                        irqSelectHigh;
	logic [`LSTBC_TRIM_W-1:0]          trimValue;
	logic [11:0]                       trimMag;
	logic                              slotHit;
	logic                              trimAdd;
	logic                              trimSkip;
	logic [15:0]                       irqSelectWord;
	logic [7:0]                        slowTaps;
	logic                              wrByte;
	logic                              wrWord;
	logic                              tapClear;

	// Slow clock made as an enable: toggles every HALF_CYC system cycles
	// HALF_CYC must be at least two
	assign halfTick = (halfCnt == 8'(HALF_CYC - 1));
	assign slowFall = halfTick & slowClock;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			halfCnt   <= 8'h00;
			slowClock <= 1'b0;
		end else if (halfTick) begin
			halfCnt   <= 8'h00;
			slowClock <= ~slowClock;
		end else begin
			halfCnt <= halfCnt + 8'h01;
		end
	end

	// Trim: one slot per 1024 advances of the adjusted stage
	assign trimValue = {trimHigh[2:0], trimLow};
	assign trimMag   = trimValue[`LSTBC_TRIM_W-1] ?
		12'(-{trimValue[`LSTBC_TRIM_W-1], trimValue}) : {1'b0, trimValue}; // R12
	assign slotHit   = (trimPhase[`LSTBC_TRIM_SLOT_LSB-1:0] == 10'h000) &&
		({1'b0, trimPhase[`LSTBC_TRIM_PHASE_W-1:`LSTBC_TRIM_SLOT_LSB]} < trimMag); // R21
	// Positive codes add a count in a slot, negative codes drop one
	assign trimAdd   = slotHit & ~trimValue[`LSTBC_TRIM_W-1];
	assign trimSkip  = slotHit & trimValue[`LSTBC_TRIM_W-1];

	// 8 kHz stage and above advance when the 16 kHz stage falls
	assign upperAdvance = slowFall & slowDividerChain[0];

	// Any write to the readback clears it, whatever the data
	assign wrByte   = link.sfrSel & link.sfrWrite & ~link.sfrWord;
	assign wrWord   = link.sfrSel & link.sfrWrite & link.sfrWord;
	assign tapClear = link.sfrSel & link.sfrWrite & (link.sfrAddr == `LSTBC_ADDR_TAPS);

	// Next chain value; a readback write wins over an advance in the same cycle
	always_comb begin
		next_chain = slowDividerChain;
		if (slowFall) begin
			next_chain[0] = ~slowDividerChain[0]; // R1 R14
		end
		if (upperAdvance && !trimSkip) begin
			next_chain[`LSTBC_CHAIN_W-1:1] = slowDividerChain[`LSTBC_CHAIN_W-1:1] +
				(trimAdd ? 14'h0002 : 14'h0001); // R14 R21
		end
		if (tapClear) begin
			next_chain[`LSTBC_CHAIN_W-1:`LSTBC_SLOW_LSB] = 8'h00; // R4
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			slowDividerChain <= `LSTBC_RST_CHAIN; // R2
		end else begin
			slowDividerChain <= next_chain;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			trimPhase <= '0;
		end else if (upperAdvance) begin
			trimPhase <= trimPhase + 21'h000001; // R21
		end
	end

	// Trim bytes; reserved bits are masked and read back as zero
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			trimLow  <= `LSTBC_RST_TRIM_LO; // R15
			trimHigh <= `LSTBC_RST_TRIM_HI;
		end else if (wrWord && link.sfrAddr == `LSTBC_ADDR_TRIM_LO) begin
			trimLow  <= link.sfrWdata[7:0]; // R15
			trimHigh <= link.sfrWdata[15:8] & `LSTBC_MASK_TRIM_HI;
		end else if (wrByte && link.sfrAddr == `LSTBC_ADDR_TRIM_LO) begin
			trimLow <= link.sfrWdata[7:0]; // R15
		end else if (wrByte && link.sfrAddr == `LSTBC_ADDR_TRIM_HI) begin
			trimHigh <= link.sfrWdata[7:0] & `LSTBC_MASK_TRIM_HI;
		end
	end

	// Interrupt select bytes; a change may itself give a tick
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			irqSelectLow  <= `LSTBC_RST_SEL_LO; // R10
			irqSelectHigh <= `LSTBC_RST_SEL_HI;
		end else if (wrWord && link.sfrAddr == `LSTBC_ADDR_SEL_LO) begin
			irqSelectLow  <= link.sfrWdata[7:0] & `LSTBC_MASK_SEL_LO; // R7 R8
			irqSelectHigh <= link.sfrWdata[15:8] & `LSTBC_MASK_SEL_HI; // R9
		end else if (wrByte && link.sfrAddr == `LSTBC_ADDR_SEL_LO) begin
			irqSelectLow <= link.sfrWdata[7:0] & `LSTBC_MASK_SEL_LO;
		end else if (wrByte && link.sfrAddr == `LSTBC_ADDR_SEL_HI) begin
			irqSelectHigh <= link.sfrWdata[7:0] & `LSTBC_MASK_SEL_HI;
		end
	end

	assign slowTaps      = slowDividerChain[`LSTBC_CHAIN_W-1:`LSTBC_SLOW_LSB];
	assign irqSelectWord = {irqSelectHigh, irqSelectLow};

	// Acknowledge one cycle after every request
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			link.sfrAck <= 1'b0;
		end else begin
			link.sfrAck <= link.sfrSel;
		end
	end

	// Read data one cycle after the request; taps are live, not latched
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			link.sfrRdata <= 16'h0000;
		end else if (link.sfrSel && !link.sfrWrite) begin
			case (link.sfrAddr)
				`LSTBC_ADDR_TAPS: link.sfrRdata <= {8'h00, slowTaps}; // R3
				`LSTBC_ADDR_TRIM_LO: link.sfrRdata <= link.sfrWord ?
					{trimHigh, trimLow} : {8'h00, trimLow};
				`LSTBC_ADDR_TRIM_HI: link.sfrRdata <= {8'h00, trimHigh};
				`LSTBC_ADDR_SEL_LO: link.sfrRdata <= link.sfrWord ?
					irqSelectWord : {8'h00, irqSelectLow};
				`LSTBC_ADDR_SEL_HI: link.sfrRdata <= {8'h00, irqSelectHigh};
				default: link.sfrRdata <= 16'h0000;
			endcase
		end
	end

	// Falling edge of each selected tap, caught from any cause
	genvar n;
	generate
		for (n = 0; n < 3; n++) begin : g_tick
			localparam int SelLsb = 4 * n;
			lstbc_pkg::lstbc_tap_sel_t sel;
			logic                      selTap;
			logic                      selTapPrev;
			assign sel    = irqSelectWord[SelLsb+2:SelLsb]; // R7 R8 R9
			assign selTap = slowTaps[sel]; // R10
			always_ff @(posedge clk_sys or posedge sys_rst) begin
				if (sys_rst) begin
					// Resets low like an idle tap, so no false edge follows reset
					selTapPrev       <= 1'b0;
					link.tickIrq[n]  <= 1'b0;
				end else begin
					selTapPrev      <= selTap;
					link.tickIrq[n] <= selTapPrev & ~selTap; // R5 R6 R11 R18 R20
				end
			end
		end
	endgenerate

	// Tap levels for the peripherals that take base clocks
	assign tapBus = {slowDividerChain, slowClock}; // R1
endmodule : lstbc_device

/* rtl/lstbc_host.sv */
// Controller end: APB registers that drive the register port and latch ticks
`timescale 1ns/10ps
`include "lstbc_consts.svh"
module lstbc_host (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	lstbc_if.host            link,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);
	lstbc_pkg::lstbc_host_state_t state;
	logic [15:0]                  cmdAddr;
	logic [15:0]                  cmdWdata;
	logic [15:0]                  readData;
	logic [2:0]                   reqFlags;
	logic [2:0]                   reqEnable;
	logic                         apbWrite;
	logic                         startCmd;
	logic                         mapped;

	assign pready   = 1'b1;
	assign apbWrite = psel & penable & pwrite;
	assign startCmd = apbWrite & (paddr == `LSTBC_HOST_CMD) & (state == lstbc_pkg::HOST_IDLE);
	assign mapped   = (paddr == `LSTBC_HOST_ADDR) || (paddr == `LSTBC_HOST_WDATA) ||
		(paddr == `LSTBC_HOST_CMD) || (paddr == `LSTBC_HOST_STATUS) ||
		(paddr == `LSTBC_HOST_RDATA) || (paddr == `LSTBC_HOST_REQ) ||
		(paddr == `LSTBC_HOST_ENABLE);
	assign pslverr  = psel & penable & ~mapped;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cmdAddr   <= 16'h0000;
			cmdWdata  <= 16'h0000;
			reqEnable <= `LSTBC_RST_ENABLE;
		end else if (apbWrite) begin
			case (paddr)
				`LSTBC_HOST_ADDR: cmdAddr <= pwdata[15:0];
				`LSTBC_HOST_WDATA: cmdWdata <= pwdata[15:0];
				`LSTBC_HOST_ENABLE: reqEnable <= pwdata[2:0]; // R17
				default: begin
				end
			endcase
		end
	end

	// One register-port transfer per command
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state         <= lstbc_pkg::HOST_IDLE;
			link.sfrSel   <= 1'b0;
			link.sfrWrite <= 1'b0;
			link.sfrWord  <= 1'b0;
			link.sfrAddr  <= 16'h0000;
			link.sfrWdata <= 16'h0000;
			readData      <= 16'h0000;
		end else begin
			case (state)
				lstbc_pkg::HOST_IDLE: begin
					if (startCmd) begin
						link.sfrSel   <= 1'b1;
						link.sfrWrite <= pwdata[`LSTBC_CMD_WRITE_BIT];
						link.sfrWord  <= pwdata[`LSTBC_CMD_WORD_BIT];
						link.sfrAddr  <= cmdAddr;
						link.sfrWdata <= cmdWdata;
						state         <= lstbc_pkg::HOST_REQ;
					end
				end
				lstbc_pkg::HOST_REQ: begin
					link.sfrSel <= 1'b0;
					state       <= lstbc_pkg::HOST_WAIT;
				end
				lstbc_pkg::HOST_WAIT: begin
					if (link.sfrAck) begin
						if (!link.sfrWrite) begin
							readData <= link.sfrRdata; // R16
						end
						state <= lstbc_pkg::HOST_IDLE;
					end
				end
				default: begin
					link.sfrSel <= 1'b0;
					state       <= lstbc_pkg::HOST_IDLE;
				end
			endcase
		end
	end

	// Sticky request flags; a new tick wins over a clear in the same cycle
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			reqFlags <= 3'h0;
		end else begin
			logic [2:0] next_flags;
			next_flags = reqFlags;
			if (apbWrite && paddr == `LSTBC_HOST_REQ) begin
				next_flags = next_flags & ~pwdata[2:0]; // R17 R19
			end
			reqFlags <= next_flags | (link.tickIrq & reqEnable); // R18 R17
		end
	end

	// Read data captured in the setup cycle
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			case (paddr)
				`LSTBC_HOST_ADDR: prdata <= {16'h0000, cmdAddr};
				`LSTBC_HOST_WDATA: prdata <= {16'h0000, cmdWdata};
				`LSTBC_HOST_STATUS: prdata <= {31'h0, state != lstbc_pkg::HOST_IDLE};
				`LSTBC_HOST_RDATA: prdata <= {16'h0000, readData};
				`LSTBC_HOST_REQ: prdata <= {29'h0, reqFlags};
				`LSTBC_HOST_ENABLE: prdata <= {29'h0, reqEnable};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule : lstbc_host

/* verif/lstbc_chk.sv */
// Link and tap checks for the time base pair
`timescale 1ns/10ps
module lstbc_chk (
	input	wire logic		clk_sys,
	input	wire logic		sys_rst,
	input	wire logic		sfrSel,
	input	wire logic		sfrWrite,
	input	wire logic		sfrWord,
	input	wire logic [15:0]	sfrAddr,
	input	wire logic [15:0]	sfrWdata,
	input	wire logic [15:0]	sfrRdata,
	input	wire logic		sfrAck,
	input	wire logic [2:0]	tickIrq,
	input	wire logic [15:0]	tapBus
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	logic [10:0]	selW;
	logic [2:0]	selTap;
	logic		tapClr;
	assign tapClr = sfrSel && sfrWrite && sfrAddr == 16'hF060;
	// Shadow of the select word
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			selW <= 11'h630;
		end else if (sfrSel && sfrWrite && sfrAddr == 16'hF064) begin
			selW[7:0] <= sfrWdata[7:0] & 8'h77;
			if (sfrWord) begin
				selW[10:8] <= sfrWdata[10:8];
			end
		end else if (sfrSel && sfrWrite && !sfrWord && sfrAddr == 16'hF065) begin
			selW[10:8] <= sfrWdata[2:0];
		end
	end
	assign selTap[0] = tapBus[8 + selW[2:0]];
	assign selTap[1] = tapBus[8 + selW[6:4]];
	assign selTap[2] = tapBus[8 + selW[10:8]];
	ack_after_sel_a: assert property (sfrSel |=> sfrAck)
		else $error("register port gave no answer");
	ack_cause_a: assert property (sfrAck |-> $past(sfrSel))
		else $error("answer without request");
	tick_single_a: assert property ((tickIrq & $past(tickIrq)) == 3'h0)
		else $error("tick longer than one cycle");
	tap_clear_a: assert property (tapClr |=> tapBus[15:8] == 8'h00)
		else $error("slow taps not cleared");
	tap_read_a: assert property (sfrSel && !sfrWrite && sfrAddr == 16'hF060
		|=> sfrRdata == {8'h00, $past(tapBus[15:8])}) else $error("readback differs");
	chain_ripple_a: assert property ($rose(tapBus[9]) |-> $fell(tapBus[8]))
		else $error("chain stage moved alone");
	slow_edge_a: assert property ($rose(tapBus[1]) |-> $fell(tapBus[0]))
		else $error("chain moved off slow clock fall");
	for (genvar n = 0; n < 3; n++) begin : g_src
		tick_fall_a: assert property ($fell(selTap[n]) |=> tickIrq[n])
			else $error("falling tap gave no tick");
		tick_cause_a: assert property (tickIrq[n] |-> $past(selTap[n], 2) && !$past(selTap[n]))
			else $error("tick without falling tap");
	end
	cover property (tapClr);
	cover property ($fell(selTap[2]));
	cover property (sfrSel && !sfrWrite && sfrWord);
endmodule : lstbc_chk

/* verif/lstbc_tb.sv */
// Self-checking bench for the time base and its controller
`timescale 1ns/10ps
`include "lstbc_consts.svh"
module lstbc_tb;
	logic		clk_sys = 1'b0;
	logic		sys_rst = 1'b1;
	logic		psel = 1'b0;
	logic		penable = 1'b0;
	logic		pwrite = 1'b0;
	logic [7:0]	paddr = 8'h00;
	logic [31:0]	pwdata = 32'h0;
	logic [31:0]	prdata;
	logic		pready;
	logic		pslverr;
	logic [15:0]	tapBus;
	logic [31:0]	seen = 32'h0;
	logic		seenValid = 1'b0;
	logic [31:0]	expQ[$];
	string		nameQ[$];
	int		errors = 0;
	int		nChecks = 0;
	int		seed = 27;
	logic [31:0]	rd;
	logic [15:0]	trim;
	logic		slvErr;
	lstbc_if link();
	lstbc_device #(.HALF_CYC(2)) u_lstbc_device (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.link(link), .tapBus(tapBus));
	lstbc_host u_lstbc_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	lstbc_chk u_lstbc_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .sfrSel(link.sfrSel),
		.sfrWrite(link.sfrWrite), .sfrWord(link.sfrWord), .sfrAddr(link.sfrAddr),
		.sfrWdata(link.sfrWdata), .sfrRdata(link.sfrRdata), .sfrAck(link.sfrAck),
		.tickIrq(link.tickIrq), .tapBus(tapBus));
	always #50 clk_sys = ~clk_sys;
	task automatic tally_and_finish;
		if (errors == 0 && nChecks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] want);
		nChecks++;
		if (got !== want) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, want, got);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int i;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk_sys);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			errors++;
			tally_and_finish();
		end
		q = prdata;
		slvErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb
	// One register port transfer through the controller
	task automatic sfr(input logic wr, input logic wd, input logic [15:0] a, input logic [15:0] d,
		output logic [31:0] q);
		int i;
		logic [31:0] s;
		apb(1'b1, `LSTBC_HOST_ADDR, {16'h0, a}, s);
		apb(1'b1, `LSTBC_HOST_WDATA, {16'h0, d}, s);
		apb(1'b1, `LSTBC_HOST_CMD, {30'h0, wd, wr}, s);
		i = 0;
		do begin
			apb(1'b0, `LSTBC_HOST_STATUS, 32'h0, s);
			i++;
		end while (s[0] !== 1'b0 && i < 20);
		if (s[0] !== 1'b0) begin
			errors++;
			tally_and_finish();
		end
		apb(1'b0, `LSTBC_HOST_RDATA, 32'h0, q);
	endtask : sfr
	// Note the expectation, then hand the result to the monitor
	task automatic post(input string what, input logic [31:0] want, input logic [31:0] got);
		expQ.push_back(want);
		nameQ.push_back(what);
		seen <= got;
		seenValid <= 1'b1;
		@(posedge clk_sys);
		seenValid <= 1'b0;
	endtask : post
	task automatic rsfr(input string what, input logic wd, input logic [15:0] a,
		input logic [31:0] want);
		logic [31:0] q;
		sfr(1'b0, wd, a, 16'h0000, q);
		post(what, want, q);
	endtask : rsfr
	// Taps read twice until both readings agree
	task automatic rtaps(input string what, input logic [31:0] want);
		logic [31:0] q1;
		logic [31:0] q2;
		int i;
		i = 0;
		do begin
			sfr(1'b0, 1'b0, 16'hF060, 16'h0000, q1);
			sfr(1'b0, 1'b0, 16'hF060, 16'h0000, q2);
			i++;
		end while (q1 !== q2 && i < 4);
		post(what, want, q2);
	endtask : rtaps
	task automatic wait_tap(input logic lvl);
		int i;
		i = 0;
		while (tapBus[8] !== lvl && i < 5000) begin
			@(posedge clk_sys);
			i++;
		end
		if (tapBus[8] !== lvl) begin
			errors++;
			tally_and_finish();
		end
	endtask : wait_tap
	always @(posedge clk_sys) begin
		if (seenValid === 1'b1 && expQ.size() > 0) begin
			chk(nameQ.pop_front(), seen, expQ.pop_front());
		end
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		rsfr("trim reset", 1'b1, 16'hF062, 32'h0000);
		rsfr("select reset", 1'b1, 16'hF064, 32'h0630);
		rsfr("select high reset", 1'b0, 16'hF065, 32'h0006);
		rsfr("unmapped", 1'b0, 16'hF061, 32'h0000);
		apb(1'b0, `LSTBC_HOST_ENABLE, 32'h0, rd);
		post("enable reset", 32'h7, rd);
		apb(1'b0, 8'h1C, 32'h0, rd);
		post("host slave error", 32'h1, {rd[30:0], slvErr});
		trim = 16'($random(seed)) & 16'h07FF;
		sfr(1'b1, 1'b1, 16'hF062, trim, rd);
		rsfr("trim word", 1'b1, 16'hF062, {16'h0, trim});
		apb(1'b0, `LSTBC_HOST_ADDR, 32'h0, rd);
		post("command address", 32'h0000F062, rd);
		sfr(1'b1, 1'b0, 16'hF063, 16'h00FC, rd);
		rsfr("trim high", 1'b0, 16'hF063, 32'h0004);
		sfr(1'b1, 1'b0, 16'hF062, 16'h00A5, rd);
		rsfr("trim low byte", 1'b0, 16'hF062, 32'h00A5);
		rsfr("trim after bytes", 1'b1, 16'hF062, 32'h04A5);
		for (int k = 0; k < 8; k++) begin
			sfr(1'b1, 1'b0, 16'hF064, {8'h00, 1'b1, 3'(k), 1'b1, 3'(7 - k)}, rd);
			sfr(1'b1, 1'b0, 16'hF065, 16'(k), rd);
			rsfr("select code", 1'b1, 16'hF064, {21'h0, 3'(k), 1'b0, 3'(k), 1'b0, 3'(7 - k)});
		end
		sfr(1'b1, 1'b1, 16'hF064, 16'h0000, rd);
		for (int en = 0; en < 2; en++) begin
			apb(1'b1, `LSTBC_HOST_ENABLE, (en == 1) ? 32'h7 : 32'h0, rd);
			wait_tap(1'b0);
			wait_tap(1'b1);
			apb(1'b1, `LSTBC_HOST_REQ, 32'h7, rd);
			sfr(1'b1, 1'b0, 16'hF060, 16'h00FF, rd);
			apb(1'b0, `LSTBC_HOST_REQ, 32'h0, rd);
			post("ticks from clear", (en == 1) ? 32'h7 : 32'h0, rd);
			apb(1'b1, `LSTBC_HOST_REQ, 32'h7, rd);
			apb(1'b0, `LSTBC_HOST_REQ, 32'h0, rd);
			post("flags cleared", 32'h0, rd);
			rtaps("taps after clear", 32'h0000);
		end
		apb(1'b1, `LSTBC_HOST_REQ, 32'h7, rd);
		wait_tap(1'b1);
		wait_tap(1'b0);
		repeat (3) @(posedge clk_sys);
		apb(1'b0, `LSTBC_HOST_REQ, 32'h0, rd);
		post("ticks from tap", 32'h7, rd);
		rtaps("taps after fall", 32'h0002);
		@(posedge clk_sys);
		if (expQ.size() != 0) begin
			errors++;
		end
		tally_and_finish();
	end
endmodule : lstbc_tb
